// file: hw/rsf_top.sv
// rsf_top: resonance suppression filters with two notch stages, a
// low-pass stage and automatic resonance search, behind a Wishbone slave.
// assumes: classic Wishbone master on clk_i, command samples on clk_i.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rsf_top #(
    parameter int     FS_HZ         = rsf_pkg::SAMPLE_HZ,
    parameter longint SETTLE_CYCLES = rsf_pkg::SETTLE_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [11:0]          wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire rsf_pkg::rsf_sample_t cmd_i,
    output var  rsf_pkg::rsf_sample_t cmd_o,
    output logic                      search_active_o
);
    localparam logic [15:0] LP_NUM      = 16'(rsf_pkg::LP_NUM_SCALED / FS_HZ);
    localparam logic [15:0] WIN_LAST    = 16'(FS_HZ - 1);
    localparam logic [39:0] SETTLE_LAST = 40'(SETTLE_CYCLES - 1);
    localparam logic [4:0]  DIV_STEPS   = 5'h10;

    rsf_pkg::rsf_top_state_t s;
    rsf_pkg::rsf_top_state_t next_s;

    rsf_pkg::rsf_notch_cfg_t cfg   [2];
    rsf_pkg::rsf_sample_t    chain [3];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge(input logic [15:0] cur,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        merge = {sel[1] ? dat[15:8] : cur[15:8], sel[0] ? dat[7:0] : cur[7:0]};
    endfunction

    function automatic logic freq_ok(input logic [15:0] v);
        freq_ok = (v == 16'h0000) || (v >= rsf_pkg::FREQ_MIN && v <= rsf_pkg::FREQ_MAX);
    endfunction

    // ------------------------------------------------------------
    // notch cascade
    // ------------------------------------------------------------
    assign cfg[0]   = s.n1;
    assign cfg[1]   = s.n2;
    assign chain[0] = cmd_i;

    for (genvar g = 0; g < 2; g++) begin : g_notch
        rsf_notch_stage #(
            .FS_HZ (FS_HZ)
        ) u_stage (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .cfg_i (cfg[g]),
            .in_i  (chain[g]),
            .out_o (chain[g+1])
        );
    end

    logic               bus_req;
    logic               bus_wr;
    logic [9:0]         widx;
    logic [15:0]        wval;
    logic [16:0]        div_try;
    logic signed [23:0] lp_x;
    logic signed [24:0] lp_diff;
    logic signed [41:0] lp_prod;
    logic [15:0]        mag;
    logic [15:0]        fnd;
    logic [15:0]        dep1;
    logic [15:0]        dep2;
    logic               found;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s  = s;
        bus_req = wb_cyc_i && wb_stb_i && !s.ack;
        bus_wr  = bus_req && wb_we_i;
        widx    = wb_adr_i[11:2];
        wval    = 16'h0000;
        found   = 1'b0;
        fnd     = {1'b0, s.cross_cnt[15:1]};
        mag     = cmd_i.data[15] ? 16'(-cmd_i.data) : 16'(cmd_i.data);
        dep1    = s.n1.depth + rsf_pkg::DEPTH_STEP;
        dep2    = s.n2.depth + rsf_pkg::DEPTH_STEP;
        lp_x    = {chain[2].data, 8'h00};
        lp_diff = lp_x - s.lp_y;
        lp_prod = lp_diff * $signed({1'b0, s.alpha});
        div_try = {s.div_rem[15:0], s.div_quo[15]} - {1'b0, s.lp_tc};
        next_s.ack = bus_req;

        // alpha = LP_NUM / time constant, one quotient bit per cycle
        if (s.div_busy) begin
            if (!div_try[16]) begin
                next_s.div_rem = div_try;
                next_s.div_quo = {s.div_quo[14:0], 1'b1};
            end else begin
                next_s.div_rem = {s.div_rem[15:0], s.div_quo[15]};
                next_s.div_quo = {s.div_quo[14:0], 1'b0};
            end
            next_s.div_cnt = s.div_cnt + 5'h01;
            if (s.div_cnt == DIV_STEPS - 5'h01) begin
                next_s.div_busy = 1'b0;
                next_s.alpha    = {s.div_quo[14:0], !div_try[16]};
            end
        end

        // low-pass stage, last in the cascade
        next_s.out.valid = chain[2].valid;
        if (chain[2].valid) begin
            if (s.lp_tc == 16'h0000) begin
                next_s.lp_y     = lp_x;
                next_s.out.data = chain[2].data;
            end else begin
                next_s.lp_y     = s.lp_y + lp_prod[39:16];
                next_s.out.data = next_s.lp_y[23:8];
            end
        end

        // resonance detector: zero crossings over one second give Hz
        if (cmd_i.valid) begin
            next_s.prev_sign = cmd_i.data[15];
            if (cmd_i.data[15] != s.prev_sign) begin
                next_s.cross_cnt = s.cross_cnt + 16'h0001;
            end
            if (mag > s.peak) begin
                next_s.peak = mag;
            end
            next_s.win_cnt = s.win_cnt + 16'h0001;
            if (s.win_cnt == WIN_LAST) begin
                found            = (s.mode != rsf_pkg::MODE_OFF) &&
                                   (s.peak > rsf_pkg::PEAK_THRESH);
                next_s.res_seen  = s.peak > rsf_pkg::PEAK_THRESH;
                next_s.win_cnt   = 16'h0000;
                next_s.cross_cnt = 16'h0000;
                next_s.peak      = 16'h0000;
            end
        end
        if (fnd < rsf_pkg::FREQ_MIN) begin
            fnd = rsf_pkg::FREQ_MIN;
        end else if (fnd > rsf_pkg::FREQ_MAX) begin
            fnd = rsf_pkg::FREQ_MAX;
        end

        // mode one ends after a quiet settle time
        if (s.mode == rsf_pkg::MODE_ONCE) begin
            next_s.settle_cnt = s.settle_cnt + 40'h00_0000_0001;
            if (s.settle_cnt == SETTLE_LAST) begin
                next_s.mode = rsf_pkg::MODE_OFF;
            end
        end
        // store found points into free or matching stage
        if (found) begin
            next_s.settle_cnt = '0;
            if (s.n1.depth == 16'h0000 || s.n1.freq == fnd) begin
                next_s.n1.freq  = fnd;
                next_s.n1.depth = (dep1 > rsf_pkg::DEPTH_MAX) ? rsf_pkg::DEPTH_MAX : dep1;
            end else if (s.n2.depth == 16'h0000 || s.n2.freq == fnd) begin
                next_s.n2.freq  = fnd;
                next_s.n2.depth = (dep2 > rsf_pkg::DEPTH_MAX) ? rsf_pkg::DEPTH_MAX : dep2;
            end
        end

        // register writes take priority over the search engine
        if (bus_wr) begin
            if (widx == rsf_pkg::IDX_N1_FREQ) begin
                wval = merge(s.n1.freq, wb_dat_i, wb_sel_i);
                if (freq_ok(wval)) begin
                    next_s.n1.freq = wval;
                end
            end else if (widx == rsf_pkg::IDX_N1_DEPTH) begin
                wval = merge(s.n1.depth, wb_dat_i, wb_sel_i);
                if (wval <= rsf_pkg::DEPTH_MAX) begin
                    next_s.n1.depth = wval;
                end
            end else if (widx == rsf_pkg::IDX_N2_FREQ) begin
                wval = merge(s.n2.freq, wb_dat_i, wb_sel_i);
                if (freq_ok(wval)) begin
                    next_s.n2.freq = wval;
                end
            end else if (widx == rsf_pkg::IDX_N2_DEPTH) begin
                wval = merge(s.n2.depth, wb_dat_i, wb_sel_i);
                if (wval <= rsf_pkg::DEPTH_MAX) begin
                    next_s.n2.depth = wval;
                end
            end else if (widx == rsf_pkg::IDX_LOWPASS) begin
                wval = merge(s.lp_tc, wb_dat_i, wb_sel_i);
                if (wval <= rsf_pkg::LOWPASS_MAX) begin
                    next_s.lp_tc    = wval;
                    next_s.div_busy = wval != 16'h0000;
                    next_s.div_rem  = '0;
                    next_s.div_quo  = LP_NUM;
                    next_s.div_cnt  = '0;
                end
            end else if (widx == rsf_pkg::IDX_MODE) begin
                wval = merge({14'h0000, s.mode}, wb_dat_i, wb_sel_i);
                if (wval == {14'h0000, rsf_pkg::MODE_ONCE} ||
                    (wval == {14'h0000, rsf_pkg::MODE_CONT} && s.mode == rsf_pkg::MODE_OFF)) begin
                    // clear all four settings and start
                    next_s.n1         = '0;
                    next_s.n2         = '0;
                    next_s.mode       = wval[1:0];
                    next_s.settle_cnt = '0;
                end else if (wval == {14'h0000, rsf_pkg::MODE_CONT}) begin
                    next_s.mode = rsf_pkg::MODE_CONT;
                end else if (wval == 16'h0000) begin
                    next_s.mode = rsf_pkg::MODE_OFF;
                end
            end
        end

        // register reads; unmapped words answer zero
        next_s.rdata = 32'h0000_0000;
        if (bus_req && !wb_we_i) begin
            if (widx == rsf_pkg::IDX_N1_FREQ) begin
                next_s.rdata[15:0] = s.n1.freq;
            end else if (widx == rsf_pkg::IDX_N1_DEPTH) begin
                next_s.rdata[15:0] = s.n1.depth;
            end else if (widx == rsf_pkg::IDX_N2_FREQ) begin
                next_s.rdata[15:0] = s.n2.freq;
            end else if (widx == rsf_pkg::IDX_N2_DEPTH) begin
                next_s.rdata[15:0] = s.n2.depth;
            end else if (widx == rsf_pkg::IDX_LOWPASS) begin
                next_s.rdata[15:0] = s.lp_tc;
            end else if (widx == rsf_pkg::IDX_MODE) begin
                next_s.rdata[1:0] = s.mode;
            end else if (widx == rsf_pkg::IDX_STATUS) begin
                next_s.rdata[2:0] = {s.res_seen, s.div_busy, s.mode != rsf_pkg::MODE_OFF};
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.n1.freq  <= rsf_pkg::FREQ_RESET;
            s.n1.depth <= rsf_pkg::DEPTH_RESET;
            s.n2.freq  <= rsf_pkg::FREQ_RESET;
            s.n2.depth <= rsf_pkg::DEPTH_RESET;
            s.lp_tc    <= rsf_pkg::LOWPASS_RESET;
            // alpha for the reset time constant, so no divide is pending
            s.alpha    <= 16'(LP_NUM / rsf_pkg::LOWPASS_RESET);
            s.mode     <= rsf_pkg::MODE_OFF;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o        = s.ack;
    assign wb_dat_o        = s.rdata;
    assign cmd_o           = s.out;
    assign search_active_o = s.mode != rsf_pkg::MODE_OFF;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a one-cycle answer");

    freq_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        freq_ok(s.n1.freq) && freq_ok(s.n2.freq))
        else $error("notch frequency outside its range");

    depth_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s.n1.depth <= rsf_pkg::DEPTH_MAX && s.n2.depth <= rsf_pkg::DEPTH_MAX)
        else $error("notch depth above limit");

    lp_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (chain[2].valid && s.lp_tc == 16'h0000) |=> cmd_o.data == $past(chain[2].data))
        else $error("low-pass bypass altered the sample");

    mode_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && widx == rsf_pkg::IDX_MODE && wb_sel_i[0] && wb_dat_i[7:0] == 8'h01
         && (!wb_sel_i[1] || wb_dat_i[15:8] == 8'h00))
        |=> (s.n1 == '0 && s.n2 == '0 && s.mode == rsf_pkg::MODE_ONCE))
        else $error("mode one write did not clear settings");

    mode_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && widx == rsf_pkg::IDX_MODE && (&wb_sel_i[1:0]) && wb_dat_i[15:0] == 16'h0000
         && s.mode != rsf_pkg::MODE_OFF)
        |=> (s.mode == rsf_pkg::MODE_OFF && $stable(s.n1) && $stable(s.n2)))
        else $error("mode zero write changed settings");

    mode_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr && widx == rsf_pkg::IDX_MODE && (&wb_sel_i[1:0]) && wb_dat_i[15:0] == 16'h0002
         && s.mode != rsf_pkg::MODE_OFF && !found)
        |=> (s.mode == rsf_pkg::MODE_CONT && $stable(s.n1) && $stable(s.n2)))
        else $error("continuous write cleared settings");

    settle_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == rsf_pkg::MODE_ONCE && s.settle_cnt == SETTLE_LAST && !found && !bus_wr)
        |=> s.mode == rsf_pkg::MODE_OFF)
        else $error("mode one did not end after settling");

    cont_stays_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == rsf_pkg::MODE_CONT && !bus_wr) |=> s.mode == rsf_pkg::MODE_CONT)
        else $error("continuous search ended on its own");

    chain_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd_i.valid |-> ##3 cmd_o.valid)
        else $error("cascade latency not three cycles");

endmodule
`default_nettype wire

// file: common/rsf_pkg.sv
// rsf_pkg: constants, register indices and carrier types of the
// resonance suppression filter block.
// assumes: 100 MHz system clock and one command sample stream.
package rsf_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          SAMPLE_HZ       = 20_000;
    localparam int          SETTLE_MINUTES  = 20;
    localparam int          SEC_PER_MINUTE  = 60;
    localparam longint      SETTLE_CYCLES   = longint'(SETTLE_MINUTES) *
                                              longint'(SEC_PER_MINUTE) * longint'(CLK_HZ);
    // 2*pi*65536, frequency word scale of the notch stages
    localparam int          TWO_PI_Q16      = 411_775;
    // 65536 * 10000: alpha numerator, time constant in 0.1 ms units
    localparam int          LP_NUM_SCALED   = 655_360_000;

    // ------------------------------------------------------------
    // register word indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [9:0]  IDX_LOWPASS     = 10'h232;
    localparam logic [9:0]  IDX_N1_FREQ     = 10'h256;
    localparam logic [9:0]  IDX_N1_DEPTH    = 10'h258;
    localparam logic [9:0]  IDX_N2_FREQ     = 10'h25a;
    localparam logic [9:0]  IDX_N2_DEPTH    = 10'h25c;
    localparam logic [9:0]  IDX_MODE        = 10'h25e;
    localparam logic [9:0]  IDX_STATUS      = 10'h260;

    // ------------------------------------------------------------
    // reset values and legal ranges
    // ------------------------------------------------------------
    localparam logic [15:0] FREQ_RESET      = 16'h03e8;
    localparam logic [15:0] DEPTH_RESET     = 16'h0000;
    localparam logic [15:0] LOWPASS_RESET   = 16'h0002;
    localparam logic [15:0] FREQ_MIN        = 16'h0032;
    localparam logic [15:0] FREQ_MAX        = 16'h07d0;
    localparam logic [15:0] DEPTH_MAX       = 16'h0020;
    localparam logic [15:0] DEPTH_STEP      = 16'h0004;
    localparam logic [15:0] LOWPASS_MAX     = 16'h03e9;
    localparam logic [15:0] PEAK_THRESH     = 16'h2000;

    localparam logic [1:0]  MODE_OFF        = 2'h0;
    localparam logic [1:0]  MODE_ONCE       = 2'h1;
    localparam logic [1:0]  MODE_CONT       = 2'h2;

    // ------------------------------------------------------------
    // carriers and state records
    // ------------------------------------------------------------
    typedef struct packed {
        logic               valid;
        logic signed [15:0] data;
    } rsf_sample_t;

    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] depth;
    } rsf_notch_cfg_t;

    typedef struct packed {
        logic signed [23:0] lp;
        logic signed [23:0] bp;
        rsf_sample_t        out;
    } rsf_stage_state_t;

    typedef struct packed {
        logic               ack;
        logic [31:0]        rdata;
        rsf_notch_cfg_t     n1;
        rsf_notch_cfg_t     n2;
        logic [15:0]        lp_tc;
        logic [1:0]         mode;
        logic [15:0]        alpha;
        logic [16:0]        div_rem;
        logic [15:0]        div_quo;
        logic [4:0]         div_cnt;
        logic               div_busy;
        logic signed [23:0] lp_y;
        rsf_sample_t        out;
        logic [15:0]        win_cnt;
        logic [15:0]        cross_cnt;
        logic [15:0]        peak;
        logic               prev_sign;
        logic               res_seen;
        logic [39:0]        settle_cnt;
    } rsf_top_state_t;

endpackage

// file: hw/rsf_notch_stage.sv
// rsf_notch_stage: one state-variable notch stage with programmable
// centre frequency and attenuation depth; one cycle of latency.
// assumes: samples arrive no faster than one per clock, same clock domain.
`timescale 1ns/1ps
`default_nettype none
module rsf_notch_stage #(
    parameter int FS_HZ = rsf_pkg::SAMPLE_HZ
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire rsf_pkg::rsf_notch_cfg_t cfg_i,
    input  wire rsf_pkg::rsf_sample_t    in_i,
    output var  rsf_pkg::rsf_sample_t    out_o
);
    localparam int F_SCALE = (rsf_pkg::TWO_PI_Q16 * 1024) / FS_HZ;

    rsf_pkg::rsf_stage_state_t s;
    rsf_pkg::rsf_stage_state_t next_s;

    logic               enabled;
    logic [15:0]        f;
    logic [31:0]        f_wide;
    logic [8:0]         k;
    logic signed [23:0] x;
    logic signed [25:0] hp;
    logic signed [42:0] p1;
    logic signed [40:0] p2;
    logic signed [33:0] p3;
    logic signed [24:0] yw;

    // ------------------------------------------------------------
    // filter arithmetic
    // ------------------------------------------------------------
    always_comb begin
        next_s  = s;
        enabled = (cfg_i.freq != 16'h0000) && (cfg_i.depth != 16'h0000);
        f_wide  = (32'(cfg_i.freq) * 32'(F_SCALE)) >> 10;
        f       = f_wide[15:0];
        // depth 32 dB maps to a full-depth notch
        k       = {cfg_i.depth[5:0], 3'b000};
        x       = {in_i.data, 8'h00};
        hp      = x - s.lp - s.bp;
        p1      = hp * $signed({1'b0, f});
        p2      = s.bp * $signed({1'b0, f});
        p3      = s.bp * $signed({1'b0, k});
        yw      = x - $signed(p3[31:8]);
        next_s.out.valid = in_i.valid;
        if (in_i.valid) begin
            if (enabled) begin
                next_s.bp = s.bp + p1[39:16];
                next_s.lp = s.lp + p2[39:16];
                if (yw[24] != yw[23]) begin
                    next_s.out.data = yw[24] ? 16'sh8000 : 16'sh7fff;
                end else begin
                    next_s.out.data = yw[23:8];
                end
            end else begin
                next_s.bp       = '0;
                next_s.lp       = '0;
                next_s.out.data = in_i.data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_o = s.out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    stage_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_i.valid && !enabled) |=> (out_o.valid && out_o.data == $past(in_i.data)))
        else $error("disabled notch stage altered the sample");

endmodule
`default_nettype wire

// file: testbench/tb.sv
// tb: self-checking bench for the resonance suppression filter top.
// assumes: rsf_pkg compiled first; short settle and window counts for simulation.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                 clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, search_active_o;
    logic [11:0]          wb_adr_i;
    logic [3:0]           wb_sel_i;
    logic [31:0]          wb_dat_i, wb_dat_o;
    logic [15:0]          q;
    rsf_pkg::rsf_sample_t cmd_i, cmd_o;
    int                   failures, checks_done, cycles;
    // ----------------------------------------------------------------
    // register rows: byte address, write value, expected read-back
    // ----------------------------------------------------------------
    localparam logic [43:0] ROWS [0:10] = '{44'h958_0032_0032, 44'h958_07d0_07d0,
        44'h958_07d1_07d0, 44'h958_0000_0000, 44'h960_0020_0020, 44'h960_0021_0020,
        44'h968_07d0_07d0, 44'h968_0031_07d0, 44'h970_0020_0020, 44'h8c8_03e9_03e9,
        44'h8c8_03ea_03e9};
    rsf_top #(.FS_HZ(200), .SETTLE_CYCLES(200)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cmd_i(cmd_i), .cmd_o(cmd_o), .search_active_o(search_active_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // classic single cycle; the bench waits for ack under a bound
    task automatic wb(input logic we, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
        if (n >= 50) chk("ack", 32'h0000_0001, 32'h0000_0000);
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string name);
        wb(1'b0, a, 16'h0000);
        chk(name, {16'h0000, exp}, {16'h0000, q});
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        failures    = 0;
        checks_done = 0;
        cycles      = 0;
        rst_i       = 1'b1;
        wb_cyc_i    = 1'b0;
        wb_stb_i    = 1'b0;
        wb_we_i     = 1'b0;
        wb_adr_i    = 12'h000;
        wb_sel_i    = 4'h0;
        wb_dat_i    = 32'h0000_0000;
        cmd_i       = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'h958, 16'h03e8, "n1 freq rst");
        rd(12'h960, 16'h0000, "n1 depth rst");
        rd(12'h968, 16'h03e8, "n2 freq rst");
        rd(12'h970, 16'h0000, "n2 depth rst");
        rd(12'h8c8, 16'h0002, "lowpass rst");
        $display("test reset done");
        // range limits, refused writes keep the old value
        foreach (ROWS[i]) begin
            wb(1'b1, ROWS[i][43:32], ROWS[i][31:16]);
            rd(ROWS[i][43:32], ROWS[i][15:0], "row");
        end
        wb(1'b1, 12'h990, 16'h1234);
        rd(12'h990, 16'h0000, "unmapped");
        $display("test rows done");
        // all stages disabled by zero depth, zero freq, zero time constant
        wb(1'b1, 12'h958, 16'h03e8);
        wb(1'b1, 12'h960, 16'h0000);
        wb(1'b1, 12'h968, 16'h0000);
        wb(1'b1, 12'h8c8, 16'h0000);
        @(posedge clk_i);
        cmd_i <= '{valid: 1'b1, data: 16'sh1234};
        @(posedge clk_i);
        cmd_i.valid <= 1'b0;
        // the output valid stands only between the third and fourth edge
        repeat (2) @(posedge clk_i);
        #1;
        chk("pass valid", 32'h0000_0001, {31'h0, cmd_o.valid});
        chk("pass data", 32'h0000_1234, {16'h0000, cmd_o.data});
        $display("test bypass done");
        // mode transitions: clear or keep the notch settings
        wb(1'b1, 12'h958, 16'h0064);
        wb(1'b1, 12'h978, 16'h0002);
        rd(12'h958, 16'h0000, "clear 0 to 2");
        chk("active", 32'h0000_0001, {31'h0, search_active_o});
        wb(1'b1, 12'h958, 16'h0064);
        wb(1'b1, 12'h978, 16'h0002);
        rd(12'h958, 16'h0064, "keep 2 to 2");
        wb(1'b1, 12'h978, 16'h0003);
        rd(12'h978, 16'h0002, "mode 3 refused");
        // square wave of two-sample period: the one window that closes holds
        // 198 crossings, so the search reports 99 at the simulation rate
        for (int k = 0; k < 200; k++) begin
            @(posedge clk_i);
            cmd_i <= '{valid: 1'b1, data: k[0] ? 16'sh4000 : 16'shc000};
        end
        @(posedge clk_i);
        cmd_i.valid <= 1'b0;
        rd(12'h958, 16'h0063, "found freq");
        rd(12'h960, 16'h0004, "found depth");
        rd(12'h980, 16'h0005, "status");
        wb(1'b1, 12'h978, 16'h0000);
        rd(12'h960, 16'h0004, "keep 2 to 0");
        chk("idle", 32'h0000_0000, {31'h0, search_active_o});
        wb(1'b1, 12'h978, 16'h0001);
        rd(12'h958, 16'h0000, "clear 0 to 1");
        rd(12'h978, 16'h0001, "mode once");
        repeat (400) @(posedge clk_i);
        rd(12'h978, 16'h0000, "once ends");
        $display("test modes done");
        close_out();
    end
endmodule
`default_nettype wire
